/* logic/rbtt_pkg.sv */
// constants and types shared by the read burst timing block
package rbtt_pkg;
    // command codes seen on the command/address bus
    typedef enum logic [2:0] {
        RBTT_CMD_NOP = 3'h0,
        RBTT_CMD_OPEN = 3'h1,
        RBTT_CMD_READ = 3'h2,
        RBTT_CMD_WRITE = 3'h3,
        RBTT_CMD_CLOSE = 3'h4
    } rbtt_cmd_type;
    // burst-length field encodings of mode_register_zero
    typedef enum logic [1:0] {
        RBTT_BL_FIXED8 = 2'h0,
        RBTT_BL_SELECT = 2'h1,
        RBTT_BL_FIXED4 = 2'h2,
        RBTT_BL_RSVD = 2'h3
    } rbtt_bl_type;
    // register byte offsets
    localparam logic [7:0] RBTT_OFS_MODE = 8'h00;
    localparam logic [7:0] RBTT_OFS_LAT = 8'h04;
    localparam logic [7:0] RBTT_OFS_STATUS = 8'h08;
    localparam logic [7:0] RBTT_OFS_RL = 8'h0c;
    // field positions
    localparam int RBTT_MODE_BL_LSB = 0;
    localparam int RBTT_MODE_RTC_LSB = 9;
    localparam int RBTT_LAT_CL_LSB = 0;
    localparam int RBTT_LAT_AL_LSB = 6;
    localparam int RBTT_LAT_PL_LSB = 11;
    localparam int RBTT_LAT_PAR_BIT = 16;
    localparam int RBTT_LAT_INV_BIT = 17;
    localparam int RBTT_ST_VCLOSE_BIT = 16;
    localparam int RBTT_ST_VOPEN_BIT = 17;
    localparam int RBTT_ST_LAST8_BIT = 18;
    // reset values
    localparam logic [31:0] RBTT_MODE_RST = 32'h0000_0200;
    localparam logic [31:0] RBTT_LAT_RST = 32'h0000_000b;
    // timing
    localparam int RBTT_CLK_PS = 8000;
    localparam int RBTT_RTC_MIN_PS = 7500;
    localparam int RBTT_RTC_MIN_CK = 4;
    localparam int RBTT_RTC_PS_CYC = (RBTT_RTC_MIN_PS + RBTT_CLK_PS - 1) / RBTT_CLK_PS;
    localparam int RBTT_RTC_FLOOR =
        (RBTT_RTC_PS_CYC > RBTT_RTC_MIN_CK) ? RBTT_RTC_PS_CYC : RBTT_RTC_MIN_CK;
    localparam logic [7:0] RBTT_RTC_BASE = 8'h05;
    localparam logic [6:0] RBTT_INV_ADDER = 7'h02;
    localparam logic [3:0] RBTT_BEATS8 = 4'h8;
    localparam logic [3:0] RBTT_BEATS4 = 4'h4;
endpackage

/* logic/rbtt_read_timing.sv */
// read burst timing, bank close tracking and read data return
// Function
// [RULE1] close waits additive latency plus read-to-close
// [RULE2] close also waits open-to-close minimum; auto close fires after close_gap without checking it
// [RULE3] read-to-close at least max(4 clocks, 7.5ns)
// [RULE4] reopen waits row close time after close
// [RULE5] reopen also waits row cycle time
// [RULE6] field 01: address bit 12 picks burst
// [RULE7] field 10: fixed four-beat chop
// [RULE8] field 00: fixed eight-beat burst
// [RULE9] two-clock write preamble: raise write latency; this block keeps no write latency to raise
// [RULE10] bus inversion adds two clocks latency
// [RULE11] parity adds parity latency to read latency
// [RULE12] code 001 gives read-to-close of six
// [RULE13] address bit 10 requests auto close
// [RULE14] first beat at additive plus cas latency
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
module rbtt_read_timing
    import rbtt_pkg::*;
#(
    parameter int BANKS = 16,
    parameter int COL_W = 10,
    parameter int MAX_RL = 64,
    parameter logic [7:0] OPEN_TO_CLOSE_MIN = 8'h1c,
    parameter logic [7:0] ROW_CLOSE_TIME = 8'h0b,
    parameter logic [7:0] ROW_CYCLE_TIME = 8'h27
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // command/address bus
    input wire rbtt_pkg::rbtt_cmd_type cmd_i,
    input wire logic [$clog2(BANKS)-1:0] bank_i,
    input wire logic [COL_W-1:0] col_i,
    input wire logic auto_close_address_bit_i,
    input wire logic burst_select_address_bit_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // read data stream
    output logic data_valid_o,
    output logic [COL_W-1:0] data_o,
    output logic data_last_o,
    input wire logic data_ready_i,
    // bank state
    output logic [BANKS-1:0] bank_open_o
);
    localparam int BW = $clog2(BANKS);

    // elaboration refuses sizes the logic cannot serve
    if (BANKS < 2 || BANKS > 16) $error("rbtt_read_timing: BANKS out of range");
    if (COL_W < 4) $error("rbtt_read_timing: COL_W too small");
    if (MAX_RL < 8 || MAX_RL > 127) $error("rbtt_read_timing: MAX_RL out of range");

    // decoding used by reads and writes alike
    function automatic logic burst_is_eight(input logic [1:0] field, input logic sel);
        case (field)
            // [RULE8] fixed eight beats
            RBTT_BL_FIXED8: burst_is_eight = 1'b1;
            // [RULE6] per-command select
            RBTT_BL_SELECT: burst_is_eight = sel;
            // [RULE7] fixed four-beat chop
            RBTT_BL_FIXED4: burst_is_eight = 1'b0;
            default: burst_is_eight = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [31:0] mode_reg;
    logic [31:0] lat_reg;
    logic viol_close_reg;
    logic viol_open_reg;
    logic last8_reg;
    logic [1:0] bl_field;
    logic [7:0] rtc_prog;
    logic [7:0] rtc_eff;
    logic [7:0] al8;
    logic [7:0] close_gap;
    logic [6:0] rl;
    logic is_rd;
    logic is_open;
    logic is_close;
    logic cmd_eight;
    logic wr_status;
    logic set_vclose;
    logic set_vopen;
    logic adv;

    assign bl_field = mode_reg[RBTT_MODE_BL_LSB+:2];
    assign is_rd = ce_i && (cmd_i == RBTT_CMD_READ);
    assign is_open = ce_i && (cmd_i == RBTT_CMD_OPEN);
    assign is_close = ce_i && (cmd_i == RBTT_CMD_CLOSE);
    assign cmd_eight = burst_is_eight(bl_field, burst_select_address_bit_i);
    assign wr_status = reg_wr_i && (reg_addr_i == RBTT_OFS_STATUS);
    // [RULE12] code plus five, so 001 gives six
    assign rtc_prog = RBTT_RTC_BASE + {5'h00, mode_reg[RBTT_MODE_RTC_LSB+:3]};
    // [RULE3] never below the floor
    assign rtc_eff = (rtc_prog < 8'(RBTT_RTC_FLOOR)) ? 8'(RBTT_RTC_FLOOR) : rtc_prog;
    assign al8 = {3'h0, lat_reg[RBTT_LAT_AL_LSB+:5]};
    // [RULE1] internal read sits additive latency after the command
    assign close_gap = al8 + rtc_eff;

    // read latency: [RULE14] base, [RULE11] parity, [RULE10] inversion
    always_comb begin
        rl = {1'b0, lat_reg[RBTT_LAT_CL_LSB+:6]} + {2'h0, lat_reg[RBTT_LAT_AL_LSB+:5]};
        if (lat_reg[RBTT_LAT_PAR_BIT]) begin
            rl = rl + {3'h0, lat_reg[RBTT_LAT_PL_LSB+:4]};
        end
        if (lat_reg[RBTT_LAT_INV_BIT]) begin
            rl = rl + RBTT_INV_ADDER;
        end
        if (rl > 7'(MAX_RL)) begin
            rl = 7'(MAX_RL);
        end else if (rl == 7'h00) begin
            rl = 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_reg <= RBTT_MODE_RST;
            lat_reg <= RBTT_LAT_RST;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == RBTT_OFS_MODE) mode_reg <= {20'h0, reg_wdata_i[11:9], 7'h0,
                                                          reg_wdata_i[1:0]};
            if (reg_addr_i == RBTT_OFS_LAT) lat_reg <= {14'h0, reg_wdata_i[17:0]};
        end
    end

    // sticky spacing flags, set wins over write-one-to-clear
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            viol_close_reg <= 1'b0;
            viol_open_reg <= 1'b0;
            last8_reg <= 1'b1;
        end else if (ce_i) begin
            if (set_vclose) viol_close_reg <= 1'b1;
            else if (wr_status && reg_wdata_i[RBTT_ST_VCLOSE_BIT]) viol_close_reg <= 1'b0;
            if (set_vopen) viol_open_reg <= 1'b1;
            else if (wr_status && reg_wdata_i[RBTT_ST_VOPEN_BIT]) viol_open_reg <= 1'b0;
            if (cmd_i == RBTT_CMD_READ || cmd_i == RBTT_CMD_WRITE) last8_reg <= cmd_eight;
        end
    end

    // read data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    RBTT_OFS_MODE: reg_rdata_o <= mode_reg;
                    RBTT_OFS_LAT: reg_rdata_o <= lat_reg;
                    RBTT_OFS_STATUS: reg_rdata_o <= {13'h0, last8_reg, viol_open_reg,
                                                     viol_close_reg, 16'(bank_open_o)};
                    RBTT_OFS_RL: reg_rdata_o <= {25'h0, rl};
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-bank ages and auto-close timers
    logic [BANKS-1:0] vclose_b;
    logic [BANKS-1:0] vopen_b;

    genvar g;
    generate
        for (g = 0; g < BANKS; g = g + 1) begin : g_bank
            logic [7:0] read_age_reg;
            logic [7:0] open_age_reg;
            logic [7:0] close_age_reg;
            logic [7:0] auto_reg;
            logic hit;
            logic auto_fire;
            assign hit = (bank_i == BW'(g));
            assign auto_fire = (auto_reg == 8'h01);
            // [RULE1] [RULE2] early close command is flagged
            assign vclose_b[g] = is_close && hit &&
                ((read_age_reg < close_gap) || (open_age_reg < OPEN_TO_CLOSE_MIN));
            // [RULE4] [RULE5] early reopen is flagged
            assign vopen_b[g] = is_open && hit &&
                ((close_age_reg < ROW_CLOSE_TIME) || (open_age_reg < ROW_CYCLE_TIME));
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    read_age_reg <= 8'hff;
                    open_age_reg <= 8'hff;
                    close_age_reg <= 8'hff;
                    auto_reg <= 8'h00;
                    bank_open_o[g] <= 1'b0;
                end else if (ce_i) begin
                    if (read_age_reg != 8'hff) read_age_reg <= read_age_reg + 8'h01;
                    if (open_age_reg != 8'hff) open_age_reg <= open_age_reg + 8'h01;
                    if (close_age_reg != 8'hff) close_age_reg <= close_age_reg + 8'h01;
                    if (auto_reg != 8'h00) auto_reg <= auto_reg - 8'h01;
                    if (hit && cmd_i == RBTT_CMD_READ) begin
                        read_age_reg <= 8'h01;
                        // [RULE13] auto close after additive plus read-to-close
                        if (auto_close_address_bit_i) auto_reg <= close_gap;
                    end
                    if (hit && cmd_i == RBTT_CMD_OPEN) begin
                        open_age_reg <= 8'h01;
                        bank_open_o[g] <= 1'b1;
                    end
                    if ((hit && cmd_i == RBTT_CMD_CLOSE) || auto_fire) begin
                        close_age_reg <= 8'h01;
                        bank_open_o[g] <= 1'b0;
                        auto_reg <= 8'h00;
                    end
                end
            end
        end
    endgenerate

    assign set_vclose = |vclose_b;
    assign set_vopen = |vopen_b;

    ////////////////////////////////////////////////////////////////////
    // latency delay line: valid, eight-beat flag, column
    logic [MAX_RL-1:0] dl_valid_reg;
    logic [MAX_RL-1:0] dl_eight_reg;
    logic [COL_W-1:0] dl_col_reg [MAX_RL];
    logic [6:0] ins_at;

    assign ins_at = rl - 7'h01;

    generate
        for (g = 0; g < MAX_RL; g = g + 1) begin : g_stage
            localparam int NXT = (g < MAX_RL - 1) ? g + 1 : g; // last stage has no feeder
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    dl_valid_reg[g] <= 1'b0;
                    dl_eight_reg[g] <= 1'b0;
                    dl_col_reg[g] <= '0;
                end else if (is_rd && ins_at == 7'(g)) begin
                    dl_valid_reg[g] <= 1'b1;
                    dl_eight_reg[g] <= cmd_eight;
                    dl_col_reg[g] <= col_i;
                end else if (ce_i && adv) begin
                    if (g == MAX_RL - 1) begin
                        dl_valid_reg[g] <= 1'b0;
                    end else begin
                        dl_valid_reg[g] <= dl_valid_reg[NXT];
                        dl_eight_reg[g] <= dl_eight_reg[NXT];
                        dl_col_reg[g] <= dl_col_reg[NXT];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // beat generator feeding the buffer; stalls the line when full
    logic active_reg;
    logic [3:0] beat_reg;
    logic [3:0] beats_reg;
    logic [COL_W-1:0] bcol_reg;
    logic push;
    logic buf_ready;
    logic [3:0] cur_beat;
    logic [3:0] cur_beats;
    logic [COL_W-1:0] cur_col;
    logic [COL_W:0] push_word;

    assign push = active_reg || dl_valid_reg[0];
    // a read waiting in stage 0 holds the line until the running burst ends
    assign adv = (!push || buf_ready) && !(dl_valid_reg[0] && active_reg);
    assign cur_beat = active_reg ? beat_reg : 4'h0;
    assign cur_beats = active_reg ? beats_reg : (dl_eight_reg[0] ? RBTT_BEATS8 : RBTT_BEATS4);
    assign cur_col = active_reg ? bcol_reg : dl_col_reg[0];
    assign push_word = {(cur_beat == cur_beats - 4'h1),
                        cur_col[COL_W-1:3], cur_col[2:0] + cur_beat[2:0]};

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_reg <= 1'b0;
            beat_reg <= 4'h0;
            beats_reg <= 4'h0;
            bcol_reg <= '0;
        end else if (ce_i && push && buf_ready) begin
            active_reg <= (cur_beat != cur_beats - 4'h1);
            beat_reg <= cur_beat + 4'h1;
            beats_reg <= cur_beats;
            bcol_reg <= cur_col;
        end
    end

    rbtt_skid_buf #(
        .WIDTH(COL_W + 1)
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(push),
        .in_data_i(push_word),
        .in_ready_o(buf_ready),
        .out_valid_o(data_valid_o),
        .out_data_o({data_last_o, data_o}),
        .out_ready_i(data_ready_i)
    );
endmodule // rbtt_read_timing

/* logic/rbtt_skid_buf.sv */
// two-entry buffer with registered outputs
`timescale 1ns/10ps
module rbtt_skid_buf #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic spare_valid_reg;
    logic [WIDTH-1:0] spare_reg;
    logic take_in;

    // elaboration refuses an empty word
    if (WIDTH < 1) $error("rbtt_skid_buf: WIDTH must be at least 1");

    assign take_in = in_valid_i && !spare_valid_reg;

    // head and spare slots
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
            spare_valid_reg <= 1'b0;
            spare_reg <= '0;
        end else if (ce_i) begin
            if (!out_valid_o || out_ready_i) begin
                if (spare_valid_reg) begin
                    out_data_o <= spare_reg;
                    out_valid_o <= 1'b1;
                    spare_valid_reg <= 1'b0;
                end else begin
                    out_data_o <= in_data_i;
                    out_valid_o <= in_valid_i;
                end
            end else if (take_in) begin
                spare_reg <= in_data_i;
                spare_valid_reg <= 1'b1;
            end
        end
    end

    // ready only while the spare slot is free
    assign in_ready_o = !spare_valid_reg;
endmodule // rbtt_skid_buf

/* test/rbtt_ctl_model.sv */
// memory controller model: drives commands and takes read beats
`timescale 1ns/10ps
module rbtt_ctl_model
    import rbtt_pkg::*;
#(
    parameter int BANKS = 16,
    parameter int COL_W = 10
) (
    // clock and pace
    input wire logic sys_clk_i,
    input wire logic slow_i,
    // command/address bus
    output rbtt_pkg::rbtt_cmd_type cmd_o,
    output logic [$clog2(BANKS)-1:0] bank_o,
    output logic [COL_W-1:0] col_o,
    output logic auto_close_o,
    output logic burst_sel_o,
    // read data acceptance
    output logic ready_o
);
    initial begin
        cmd_o = RBTT_CMD_NOP;
        bank_o = '0;
        col_o = '0;
        auto_close_o = 1'b0;
        burst_sel_o = 1'b0;
        ready_o = 1'b1;
    end
    // receiver pace: prompt, or refusing every other cycle
    always @(posedge sys_clk_i) begin
        ready_o <= slow_i ? ~ready_o : 1'b1;
    end
    // no write data path here, so no write latency to raise
    // one command held through its taking edge, then address lines scrambled
    task automatic issue(input rbtt_cmd_type c, input logic [$clog2(BANKS)-1:0] b,
                         input logic [COL_W-1:0] col, input logic ac, input logic bs);
        @(posedge sys_clk_i);
        cmd_o <= c;
        bank_o <= b;
        col_o <= col;
        auto_close_o <= ac;
        burst_sel_o <= bs;
        @(posedge sys_clk_i);
        cmd_o <= RBTT_CMD_NOP;
        bank_o <= ~b;
        col_o <= ~col;
        auto_close_o <= ~ac;
        burst_sel_o <= ~bs;
    endtask
endmodule // rbtt_ctl_model

/* test/rbtt_read_timing_properties.sv */
// concurrent checks on the ports of the read burst timing block
`timescale 1ns/10ps
module rbtt_read_timing_chk
    import rbtt_pkg::*;
#(
    parameter int BANKS = 16,
    parameter int COL_W = 10
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // command/address bus
    input wire rbtt_pkg::rbtt_cmd_type cmd_i,
    input wire logic [$clog2(BANKS)-1:0] bank_i,
    input wire logic [COL_W-1:0] col_i,
    input wire logic auto_close_address_bit_i,
    input wire logic burst_select_address_bit_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // read data and bank state
    input wire logic data_valid_o,
    input wire logic [COL_W-1:0] data_o,
    input wire logic data_last_o,
    input wire logic data_ready_i,
    input wire logic [BANKS-1:0] bank_open_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    // read data only in the cycle after a read strobe
    chk_rdata_idle: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i && ce_i))
        else $error("read data outside its cycle");
    chk_open_set: assert property (
        (ce_i && cmd_i == RBTT_CMD_OPEN) |=> bank_open_o[$past(bank_i)])
        else $error("open did not mark bank");
    chk_close_clear: assert property (
        (ce_i && cmd_i == RBTT_CMD_CLOSE) |=> !bank_open_o[$past(bank_i)])
        else $error("close did not clear bank");
    chk_open_cause: assert property (
        (bank_open_o & ~$past(bank_open_o)) != '0 |-> $past(ce_i && cmd_i == RBTT_CMD_OPEN))
        else $error("bank opened without open command");
    chk_stall_hold: assert property (
        (data_valid_o && !data_ready_i) |=>
        (data_valid_o && $stable(data_o) && $stable(data_last_o)))
        else $error("stalled beat changed");
    chk_last_valid: assert property (data_last_o |-> data_valid_o)
        else $error("last flag without beat");
    chk_freeze_state: assert property (!ce_i |=> $stable(bank_open_o))
        else $error("bank state moved with enable low");
    chk_close_floor: assert property (
        (ce_i && cmd_i == RBTT_CMD_READ && auto_close_address_bit_i && bank_open_o[bank_i])
        |=> bank_open_o[$past(bank_i)] ##1 bank_open_o[$past(bank_i, 2)]
        ##1 bank_open_o[$past(bank_i, 3)])
        else $error("auto close came too early");
endmodule // rbtt_read_timing_chk

bind rbtt_read_timing rbtt_read_timing_chk #(.BANKS(BANKS), .COL_W(COL_W)) chk_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cmd_i(cmd_i), .bank_i(bank_i),
    .col_i(col_i), .auto_close_address_bit_i(auto_close_address_bit_i),
    .burst_select_address_bit_i(burst_select_address_bit_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .data_valid_o(data_valid_o), .data_o(data_o),
    .data_last_o(data_last_o), .data_ready_i(data_ready_i), .bank_open_o(bank_open_o));

/* test/tb_read_burst_turnaround_timing.sv */
// self-checking bench for the read burst timing block
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_read_burst_turnaround_timing;
    import rbtt_pkg::*;
    localparam int BANKS = 16;
    localparam int COL_W = 10;
    localparam logic [1:0] FLD [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    localparam logic SEL [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    localparam int NB [5] = '{8, 4, 8, 4, 8};
    localparam logic [31:0] LAT [4] = '{32'h0002_000b, 32'h0000_200b, 32'h0001_200b,
                                        32'h0000_014b};
    localparam int RL [4] = '{13, 11, 15, 16};
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, ce = 1'b1, slow = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ac, bs, ready, data_valid, data_last;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    rbtt_cmd_type cmd;
    logic [3:0] bank;
    logic [COL_W-1:0] col, data, exp_col = '0;
    logic [BANKS-1:0] bank_open;
    int failures = 0, checks = 0, beat = 0, exp_n = 0, cyc = 0, n;
    ////////////////////////////////////////////////////////////////////////////////
    rbtt_read_timing #(.BANKS(BANKS), .COL_W(COL_W)) uut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .cmd_i(cmd), .bank_i(bank),
        .col_i(col), .auto_close_address_bit_i(ac), .burst_select_address_bit_i(bs),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .data_valid_o(data_valid), .data_o(data),
        .data_last_o(data_last), .data_ready_i(ready), .bank_open_o(bank_open));
    rbtt_ctl_model #(.BANKS(BANKS), .COL_W(COL_W)) ctl (
        .sys_clk_i(sys_clk_i), .slow_i(slow), .cmd_o(cmd), .bank_o(bank), .col_o(col),
        .auto_close_o(ac), .burst_sel_o(bs), .ready_o(ready));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial forever #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test;
        end
    end
    // beat monitor: wrapped column order and last flag
    always @(posedge sys_clk_i) begin
        if (data_valid === 1'b1 && ready === 1'b1) begin
            `CHK(data, {exp_col[COL_W-1:3], exp_col[2:0] + beat[2:0]})
            `CHK(data_last, beat == exp_n - 1)
            beat++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // read on bank 0, measure first-beat delay, then count beats
    task automatic rd_burst(input logic [COL_W-1:0] c, input logic sel, input int nb,
                            input int rl);
        exp_col = c;
        exp_n = nb;
        beat = 0;
        ctl.issue(RBTT_CMD_READ, 4'h0, c, 1'b0, sel);
        n = 0;
        while (data_valid !== 1'b1 && n < 100) begin
            @(posedge sys_clk_i);
            n++;
            #1;
        end
        if (rl > 0) `CHK(n, rl)
        repeat (40) @(posedge sys_clk_i);
        `CHK(beat, nb)
    endtask
    task automatic stop_test;
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        expect_reg(RBTT_OFS_MODE, RBTT_MODE_RST);
        expect_reg(RBTT_OFS_LAT, RBTT_LAT_RST);
        expect_reg(RBTT_OFS_RL, 32'h0000_000b);
        expect_reg(8'h10, 32'h0);
        ctl.issue(RBTT_CMD_OPEN, 4'h0, 10'h0, 1'b0, 1'b0);
        // every burst-length field value, with the address bit both ways for field 01
        for (int i = 0; i < 5; i++) begin
            reg_write(RBTT_OFS_MODE, {30'h80, FLD[i]});
            rd_burst(10'h2c5, SEL[i], NB[i], 11);
        end
        // latency adders: inversion, parity off and on, additive
        for (int i = 0; i < 4; i++) begin
            reg_write(RBTT_OFS_LAT, LAT[i]);
            expect_reg(RBTT_OFS_RL, RL[i]);
            rd_burst(10'h013, 1'b0, 8, RL[i]);
        end
        reg_write(RBTT_OFS_MODE, RBTT_MODE_RST);
        // receiver stalls every other cycle
        @(posedge sys_clk_i);
        slow <= 1'b1;
        rd_burst(10'h3ff, 1'b0, 8, 16);
        slow <= 1'b0;
        // auto close after additive 2 plus read-to-close 6
        reg_write(RBTT_OFS_LAT, 32'h0000_008b);
        ctl.issue(RBTT_CMD_OPEN, 4'h7, 10'h0, 1'b0, 1'b0);
        repeat (30) @(posedge sys_clk_i);
        exp_col = 10'h0;
        exp_n = 8;
        beat = 0;
        ctl.issue(RBTT_CMD_READ, 4'h7, 10'h0, 1'b1, 1'b1);
        repeat (7) @(posedge sys_clk_i);
        #1;
        `CHK(bank_open[7], 1'b1)
        repeat (1) @(posedge sys_clk_i);
        #1;
        `CHK(bank_open[7], 1'b0)
        `CHK(bank_open[0], 1'b1)
        repeat (30) @(posedge sys_clk_i);
        // enable low ignores a close
        ce <= 1'b0;
        ctl.issue(RBTT_CMD_CLOSE, 4'h0, 10'h0, 1'b0, 1'b0);
        ce <= 1'b1;
        #1;
        `CHK(bank_open[0], 1'b1)
        // controller spacing broken on purpose: close and reopen too soon
        reg_write(RBTT_OFS_LAT, RBTT_LAT_RST);
        exp_col = 10'h0;
        beat = 0;
        ctl.issue(RBTT_CMD_OPEN, 4'h5, 10'h0, 1'b0, 1'b0);
        ctl.issue(RBTT_CMD_READ, 4'h5, 10'h0, 1'b0, 1'b0);
        ctl.issue(RBTT_CMD_CLOSE, 4'h5, 10'h0, 1'b0, 1'b0);
        ctl.issue(RBTT_CMD_OPEN, 4'h5, 10'h0, 1'b0, 1'b0);
        repeat (20) @(posedge sys_clk_i);
        expect_reg(RBTT_OFS_STATUS, 32'h0007_0021);
        reg_write(RBTT_OFS_STATUS, 32'h0003_0000);
        expect_reg(RBTT_OFS_STATUS, 32'h0004_0021);
        // legal spacing leaves the flags clear
        repeat (40) @(posedge sys_clk_i);
        ctl.issue(RBTT_CMD_CLOSE, 4'h5, 10'h0, 1'b0, 1'b0);
        repeat (40) @(posedge sys_clk_i);
        ctl.issue(RBTT_CMD_OPEN, 4'h5, 10'h0, 1'b0, 1'b0);
        expect_reg(RBTT_OFS_STATUS, 32'h0004_0021);
        // a write with per-command select and address bit low records a chop
        reg_write(RBTT_OFS_MODE, 32'h0000_0201);
        ctl.issue(RBTT_CMD_WRITE, 4'h5, 10'h0, 1'b0, 1'b0);
        expect_reg(RBTT_OFS_STATUS, 32'h0000_0021);
        stop_test;
    end
endmodule // tb_read_burst_turnaround_timing
